//--- logic/cmm_top.sv
`timescale 1ns/1ps
module cmm_top #(
  parameter int RELAY_STEP_CYC = cmm_pkg::RELAY_STEP_CYCLES
) (
  input  logic                        sys_clk,
  input  logic                        rst,
  input  logic                        psel,
  input  logic                        penable,
  input  logic                        pwrite,
  input  logic [cmm_pkg::APB_AW-1:0]  paddr,
  input  logic [31:0]                 pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        memReq,
  output logic                        memWrite,
  output logic [cmm_pkg::ADDR_W-1:0]  memAddr,
  output logic [cmm_pkg::WORD_W-1:0]  memWData,
  input  logic [cmm_pkg::WORD_W-1:0]  memRData,
  input  logic                        memAck,
  input  logic                        localSwitch,
  input  logic                        stopClockOff,
  input  logic                        powerResetBtn,
  input  logic                        supplyFail,
  input  logic                        finalVoltage,
  input  logic                        powerOnSwitch,
  input  logic                        ccMasterClear,
  output logic                        moduleClockRun,
  output logic [cmm_pkg::RELAY_N-1:0] relayDrive,
  output logic                        supplyShutdownOut,
  output logic                        supplyShutdownOeN,
  output logic                        available,
  output logic                        lampLocal,
  output logic                        lampSystemPower,
  output logic                        lampLocalPower,
  output logic                        lampError,
  output logic                        lampRunning,
  output logic                        irq
);
  import cmm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ISSUE, ST_WAIT} cmm_seq_t;

  cmm_seq_t          state;
  logic [PIN_N-1:0]  pinS;
  logic              localS;
  logic              stopClkS;
  logic              pwrRstS;
  logic              supFailS;
  logic              finalVS;
  logic              pwrOnS;
  logic              mclr;
  logic [7:0]        ctrlReg;
  logic              startPulse;
  logic              stepPulse;
  logic              haltPulse;
  logic              clrErrPulse;
  logic [WORD_W-1:0] manualPat;
  logic [ADDR_W-1:0] addr;
  logic [1:0]        step;
  logic              running;
  logic              errFlag;
  logic [ADDR_W-1:0] errAddr;
  logic [IRQ_N-1:0]  irqStat;
  logic [IRQ_N-1:0]  irqEn;
  logic [IRQ_N-1:0]  irqSet;
  logic [IRQ_N-1:0]  irqClr;
  logic [RELAY_N-1:0] relays;
  logic [23:0]       relayTimer;
  logic              faultLatch;
  logic              faultSet;
  logic              haltEvt;
  logic              badAddr;
  cmm_mode_t         mode;
  logic              fourCycle;
  logic              lastStep;
  logic              stepComp;
  logic              seqRun;
  logic              ackNow;
  logic              opDone;
  logic              mismatch;
  logic              stopNow;
  logic              powerWant;
  logic              apbWr;
  logic              apbSetup;

  cmm_pat_if pat ();

  cmm_sync #(
    .WIDTH (PIN_N)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({ccMasterClear, powerOnSwitch, finalVoltage, supplyFail,
                powerResetBtn, stopClockOff, localSwitch}),
    .dout    (pinS)
  );

  cmm_pattern_gen u_pat (
    .sys_clk (sys_clk),
    .rst     (rst),
    .p       (pat.gen)
  );

  assign localS   = pinS[PIN_LOCAL];
  assign stopClkS = pinS[PIN_STOPCK];
  assign pwrRstS  = pinS[PIN_PWRRST];
  assign supFailS = pinS[PIN_SUPFL];
  assign finalVS  = pinS[PIN_FINALV];
  assign pwrOnS   = pinS[PIN_PWRON];
  // central master clear has no effect while the module is local
  assign mclr     = pinS[PIN_MCLR] & ~localS;

  function automatic cmm_mode_t decodeMode(input logic alt, input logic auto_sel);
    if (alt) begin
      return MODE_ALT;
    end
    return auto_sel ? MODE_AUTO : MODE_MANUAL;
  endfunction

  assign mode        = decodeMode(ctrlReg[CTRL_ALT], ctrlReg[CTRL_AUTO]);
  assign pat.mode    = mode;
  assign pat.addr    = addr;
  assign pat.manual  = manualPat;
  // manual mode always runs two cycles whatever the complement selector says
  assign fourCycle   = (mode != MODE_MANUAL) & ctrlReg[CTRL_COMP];
  assign lastStep    = fourCycle ? (step == 2'd3) : (step == 2'd1);
  assign stepComp    = fourCycle & (step == 2'd1 | step == 2'd2);
  assign seqRun      = ~(localS & stopClkS);
  assign ackNow      = (state == ST_WAIT) & memAck;
  assign opDone      = ackNow & lastStep;
  // memWData holds the expected word during reads, so one register serves both
  assign mismatch    = ackNow & ~memWrite & (memRData != memWData);
  assign stopNow     = (ctrlReg[CTRL_STOPERR] & mismatch)
                     | (opDone & ctrlReg[CTRL_STOPFIN] & (&addr));
  assign powerWant   = localS ? pwrOnS : finalVS;
  assign faultSet    = supFailS & (&relays) & ~pwrRstS;
  assign apbSetup    = psel & ~penable;
  assign apbWr       = psel & penable & pwrite;
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & badAddr;

  // the sequencer waits for the ack even with clocks stopped, so no ack is lost
  always_ff @(posedge sys_clk) begin
    if (rst | mclr) begin
      state    <= ST_IDLE;
      step     <= 2'd0;
      running  <= 1'b0;
      haltEvt  <= 1'b0;
      memReq   <= 1'b0;
      memWrite <= 1'b0;
      memAddr  <= '0;
      memWData <= '0;
    end else begin
      haltEvt <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (seqRun & startPulse & localS) begin
            running <= 1'b1;
            state   <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (seqRun) begin
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (seqRun) begin
            memReq   <= 1'b1;
            memWrite <= step[0];
            memAddr  <= addr;
            memWData <= pat.pattern ^ {WORD_W{stepComp}};
            state    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (memAck) begin
            memReq <= 1'b0;
            step   <= lastStep ? 2'd0 : step + 2'd1;
            if (stopNow | haltPulse) begin
              running <= 1'b0;
              haltEvt <= 1'b1;
              state   <= ST_IDLE;
            end else if (ctrlReg[CTRL_CONT]) begin
              state <= ST_GAP;
            end else begin
              running <= 1'b0;
              state   <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr <= '0;
    end else if (apbWr & paddr == REG_ADDR) begin
      addr <= pwdata[ADDR_W-1:0];
    end else if (stepPulse | (opDone & ~ctrlReg[CTRL_INHIBIT])) begin
      addr <= addr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst | mclr) begin
      errFlag <= 1'b0;
      errAddr <= '0;
    end else if (mismatch) begin
      errFlag <= 1'b1;
      errAddr <= memAddr;
    end else if (clrErrPulse) begin
      errFlag <= 1'b0;
    end
  end

  // relays pick up one at a time so the special supplies come up in order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      relays     <= '0;
      relayTimer <= '0;
    end else if (faultLatch | ~powerWant) begin
      relays     <= '0;
      relayTimer <= '0;
    end else if (~(&relays)) begin
      if (relayTimer == 24'(RELAY_STEP_CYC - 1)) begin
        relayTimer <= '0;
        relays     <= {relays[RELAY_N-2:0], 1'b1};
      end else begin
        relayTimer <= relayTimer + 24'd1;
      end
    end
  end

  // a failure is only sensed once all supplies are up and reset is released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      faultLatch <= 1'b0;
    end else if (faultSet) begin
      faultLatch <= 1'b1;
    end else if (pwrRstS) begin
      faultLatch <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      supplyShutdownOut <= 1'b0;
      supplyShutdownOeN <= 1'b1;
      relayDrive        <= '0;
      moduleClockRun    <= 1'b0;
      available         <= 1'b0;
    end else begin
      supplyShutdownOut <= 1'b0;
      supplyShutdownOeN <= ~faultLatch;
      relayDrive        <= relays;
      moduleClockRun    <= seqRun;
      available         <= ~localS & (&relays);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lampLocal       <= 1'b0;
      lampSystemPower <= 1'b0;
      lampLocalPower  <= 1'b0;
      lampError       <= 1'b0;
      lampRunning     <= 1'b0;
    end else begin
      lampLocal       <= localS;
      lampSystemPower <= finalVS;
      lampLocalPower  <= &relays;
      lampError       <= errFlag;
      lampRunning     <= running;
    end
  end

  assign irqSet = {faultSet & ~faultLatch, haltEvt, opDone, mismatch};
  assign irqClr = (apbWr & paddr == REG_IRQ_CLR) ? pwdata[IRQ_N-1:0] : '0;

  // a new event in the clear cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStat <= '0;
      irq     <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~irqClr) | irqSet;
      irq     <= |(irqStat & irqEn);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrlReg     <= CTRL_RESET;
      manualPat   <= '0;
      irqEn       <= '0;
      startPulse  <= 1'b0;
      stepPulse   <= 1'b0;
      haltPulse   <= 1'b0;
      clrErrPulse <= 1'b0;
    end else begin
      startPulse  <= 1'b0;
      stepPulse   <= 1'b0;
      clrErrPulse <= 1'b0;
      if (state == ST_WAIT & memAck) begin
        haltPulse <= 1'b0;
      end
      if (apbWr) begin
        unique case (paddr)
          REG_CTRL: begin
            ctrlReg     <= pwdata[7:0];
            startPulse  <= pwdata[CTRL_START];
            stepPulse   <= pwdata[CTRL_STEP];
            haltPulse   <= pwdata[CTRL_HALT] & running;
            clrErrPulse <= pwdata[CTRL_CLRERR];
          end
          REG_PAT_LO: manualPat[31:0]       <= pwdata;
          REG_PAT_HI: manualPat[WORD_W-1:32] <= pwdata[WORD_W-33:0];
          REG_IRQ_EN: irqEn                 <= pwdata[IRQ_N-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata  <= '0;
      badAddr <= 1'b0;
    end else if (apbSetup) begin
      badAddr <= 1'b0;
      prdata  <= '0;
      unique case (paddr)
        REG_CTRL:     prdata[7:0]          <= ctrlReg;
        REG_PAT_LO:   prdata               <= manualPat[31:0];
        REG_PAT_HI:   prdata[WORD_W-33:0]  <= manualPat[WORD_W-1:32];
        REG_STATUS:   prdata[11:0]         <= {mode, step, localS, faultLatch,
                                               relays, errFlag, running};
        REG_ADDR:     prdata[ADDR_W-1:0]   <= addr;
        REG_ERR_ADDR: prdata[ADDR_W-1:0]   <= errAddr;
        REG_IRQ_STAT: prdata[IRQ_N-1:0]    <= irqStat;
        REG_IRQ_CLR:  prdata               <= '0;
        REG_IRQ_EN:   prdata[IRQ_N-1:0]    <= irqEn;
        default:      badAddr              <= 1'b1;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_alt_mode_sel: assert property (ctrlReg[CTRL_ALT] |-> mode == MODE_ALT)
    else $error("alternating selector up did not pick alternating mode");
  a_manual_mode: assert property (!ctrlReg[CTRL_ALT] && !ctrlReg[CTRL_AUTO]
                                  |-> mode == MODE_MANUAL)
    else $error("manual uniform mode not selected");
  a_auto_mode: assert property (!ctrlReg[CTRL_ALT] && ctrlReg[CTRL_AUTO]
                                |-> mode == MODE_AUTO)
    else $error("automatic uniform mode not selected");
  a_manual_two_cycle: assert property (mode == MODE_MANUAL |-> !fourCycle)
    else $error("complement cycles used in manual mode");
  a_two_cycle_order: assert property (state == ST_ISSUE && seqRun && !fourCycle
      |=> memWrite == (step == 2'd1) && memWData == $past(pat.pattern))
    else $error("two-cycle operation out of order");
  a_four_cycle_order: assert property (state == ST_ISSUE && seqRun && fourCycle
      && step == 2'd1 |=> memWrite && memWData == ~$past(pat.pattern))
    else $error("complement write missing in four-cycle operation");
  a_clock_stop_hold: assert property (localS && stopClkS && state != ST_WAIT
      |=> $stable(state) && $stable(memReq))
    else $error("sequencer moved while clocks stopped");
  a_power_inhibit: assert property (pwrRstS |=> !$rose(faultLatch))
    else $error("failure sensed during power reset");
  a_shutdown_drive: assert property (faultSet |-> ##2 !supplyShutdownOeN)
    else $error("shutdown line not grounded after supply failure");
  a_addr_count: assert property (opDone && !ctrlReg[CTRL_INHIBIT] && !stepPulse
      && !(apbWr && paddr == REG_ADDR) |=> addr == $past(addr) + 1'b1)
    else $error("address counter did not advance");
  a_read_error: assert property (mismatch |=> errFlag ##1 lampError)
    else $error("read mismatch not flagged");
endmodule // cmm_top

//--- logic/cmm_pkg.sv
// How it works
// - pattern-source choice counts only while the alternating-mode selector is down
// - pattern source active and down: uniform test with operator pattern
// - pattern source active and up: uniform test with generated pattern
// - complement-cycle choice ignored in uniform manual mode
// - two-cycle operation: normal read, then normal write, per address
// - four-cycle operation: normal read, complement write, complement read, normal write
// - local mode with clock-stop off freezes all sequencing pulses except the ack that ends a memory cycle already waiting
// - power-failure sensing inhibited while power reset is held
// - own supply failure drives the shutdown line to ground
// - on line, supplies sequence only after final system voltage appears
// - off line, power switch steps a four-relay chain on its own
// - every lamp follows its flip-flop, power state or local status
// - alternating-mode selector up runs the alternating bit pattern test
// - address counter advances after each whole operation unless inhibited
package cmm_pkg;
  localparam int WORD_W  = 49;
  localparam int ADDR_W  = 12;
  localparam int APB_AW  = 12;
  localparam int PIN_N   = 7;
  localparam int IRQ_N   = 4;
  localparam int RELAY_N = 4;

  localparam logic [APB_AW-1:0] REG_CTRL     = 12'h000;
  localparam logic [APB_AW-1:0] REG_PAT_LO   = 12'h004;
  localparam logic [APB_AW-1:0] REG_PAT_HI   = 12'h008;
  localparam logic [APB_AW-1:0] REG_STATUS   = 12'h00C;
  localparam logic [APB_AW-1:0] REG_ADDR     = 12'h010;
  localparam logic [APB_AW-1:0] REG_ERR_ADDR = 12'h014;
  localparam logic [APB_AW-1:0] REG_IRQ_STAT = 12'h018;
  localparam logic [APB_AW-1:0] REG_IRQ_CLR  = 12'h01C;
  localparam logic [APB_AW-1:0] REG_IRQ_EN   = 12'h020;

  localparam int CTRL_ALT     = 0;
  localparam int CTRL_AUTO    = 1;
  localparam int CTRL_COMP    = 2;
  localparam int CTRL_CONT    = 3;
  localparam int CTRL_INHIBIT = 4;
  localparam int CTRL_STOPERR = 5;
  localparam int CTRL_STOPFIN = 6;
  localparam int CTRL_START   = 8;
  localparam int CTRL_STEP    = 9;
  localparam int CTRL_HALT    = 10;
  localparam int CTRL_CLRERR  = 11;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int IRQ_ERROR = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_HALT  = 2;
  localparam int IRQ_FAIL  = 3;

  localparam int PIN_LOCAL  = 0;
  localparam int PIN_STOPCK = 1;
  localparam int PIN_PWRRST = 2;
  localparam int PIN_SUPFL  = 3;
  localparam int PIN_FINALV = 4;
  localparam int PIN_PWRON  = 5;
  localparam int PIN_MCLR   = 6;

  localparam logic [WORD_W-1:0] ALT_WORD = 49'h1_5555_5555_5555;

  localparam int CLK_KHZ       = 25000;
  localparam int RELAY_STEP_MS = 50;
  localparam int RELAY_STEP_CYCLES = RELAY_STEP_MS * CLK_KHZ;

  typedef enum logic [1:0] {MODE_MANUAL, MODE_AUTO, MODE_ALT} cmm_mode_t;
endpackage

//--- logic/cmm_pat_if.sv
`timescale 1ns/1ps
interface cmm_pat_if;
  import cmm_pkg::*;
  cmm_mode_t         mode;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] manual;
  logic [WORD_W-1:0] pattern;
  modport gen  (input mode, input addr, input manual, output pattern);
  modport user (output mode, output addr, output manual, input pattern);
endinterface

//--- logic/cmm_sync.sv
`timescale 1ns/1ps
module cmm_sync #(
  parameter int WIDTH = 1
) (
  input  logic             sys_clk,
  input  logic             rst,
  input  logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule // cmm_sync

//--- logic/cmm_pattern_gen.sv
`timescale 1ns/1ps
module cmm_pattern_gen (
  input logic      sys_clk,
  input logic      rst,
  cmm_pat_if.gen   p
);
  import cmm_pkg::*;
  logic phase;

  // alternating_bit_pattern_mode phase flips with the low x and low y address bits
  assign phase = p.addr[0] ^ p.addr[ADDR_W/2];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p.pattern <= '0;
    end else begin
      unique case (p.mode)
        MODE_MANUAL: p.pattern <= p.manual;
        MODE_AUTO:   p.pattern <= {p.addr[0], {4{p.addr}}};
        MODE_ALT:    p.pattern <= ALT_WORD ^ {WORD_W{phase}};
        default:     p.pattern <= '0;
      endcase
    end
  end
endmodule // cmm_pattern_gen

//--- tb/cmm_mem_model.sv
`timescale 1ns/1ps
module cmm_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [48:0] memWData,
  input  wire logic [3:0]  latency,
  input  wire logic [48:0] corrupt,
  output logic      [48:0] memRData,
  output logic             memAck
);
  logic [3:0] waitCnt;
  // reads echo the expected word, so only a commanded corruption can miscompare
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memAck   <= 1'b0;
      waitCnt  <= 4'h0;
      memRData <= '0;
    end else begin
      memAck   <= 1'b0;
      // idle data toggles every cycle so a stale word never reads as valid
      memRData <= ~memRData;
      if (memReq && !memAck) begin
        if (waitCnt == latency) begin
          memAck  <= 1'b1;
          waitCnt <= 4'h0;
          if (!memWrite) memRData <= memWData ^ corrupt;
        end else waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule // cmm_mem_model

//--- tb/core_memory_maintenance_test_sequencer_bench.sv
`timescale 1ns/1ps
module core_memory_maintenance_test_sequencer_bench;
  import cmm_pkg::*;
  localparam int STEP = 8;
  localparam logic [48:0] PAT = 49'h1_2345_A5A5_0F0F;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic memReq, memWrite, memAck, moduleClockRun, supplyShutdownOut, supplyShutdownOeN;
  logic [ADDR_W-1:0] memAddr;
  logic [WORD_W-1:0] memWData, memRData, corrupt;
  logic [3:0] relayDrive, latency;
  logic localSwitch, stopClockOff, powerResetBtn, supplyFail, finalVoltage, powerOnSwitch;
  logic ccMasterClear, available, lampLocal, lampSystemPower, lampLocalPower;
  logic lampError, lampRunning, irq;
  int badCount, comparisons;

  cmm_top #(.RELAY_STEP_CYC(STEP)) i_cmm_top (.sys_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .memReq, .memWrite, .memAddr, .memWData,
    .memRData, .memAck, .localSwitch, .stopClockOff, .powerResetBtn, .supplyFail,
    .finalVoltage, .powerOnSwitch, .ccMasterClear, .moduleClockRun, .relayDrive,
    .supplyShutdownOut, .supplyShutdownOeN, .available, .lampLocal, .lampSystemPower,
    .lampLocalPower, .lampError, .lampRunning, .irq);
  cmm_mem_model i_cmm_mem_model (.sys_clk, .rst, .memReq, .memWrite, .memWData, .latency,
    .corrupt, .memRData, .memAck);

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) badCount++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic waitReq(input logic lvl);
    int n;
    n = 0;
    while (memReq !== lvl && n < 100) begin
      tick(1);
      n++;
    end
    if (n == 100) badCount++;
  endtask
  // one start per memory cycle, as the single-cycle switch demands
  task automatic cyc(input logic [31:0] ctrl, input logic w, input logic [48:0] p,
                     input logic [11:0] a);
    apb(1'b1, REG_CTRL, ctrl | 32'h0000_0100);
    waitReq(1'b1);
    chk(memWrite, w);
    chk(memWData, p);
    chk(memAddr, a);
    chk(lampRunning, 1'b1);
    waitReq(1'b0);
  endtask
  task automatic op(input logic [31:0] ctrl, input int n, input logic [48:0] p,
                    input logic [11:0] a);
    cyc(ctrl, 1'b0, p, a);
    if (n == 4) begin
      cyc(ctrl, 1'b1, ~p, a);
      cyc(ctrl, 1'b0, ~p, a);
    end
    cyc(ctrl, 1'b1, p, a);
  endtask

  task automatic tRegs;
    chk(supplyShutdownOeN, 1'b1);
    chk(irq, 1'b0);
    rdchk(REG_CTRL, 32'h0000_0000);
    rdchk(REG_ADDR, 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b1, REG_PAT_LO, PAT[31:0]);
    apb(1'b1, REG_PAT_HI, {15'h0000, PAT[48:32]});
    rdchk(REG_PAT_HI, {15'h0000, PAT[48:32]});
    $display("test regs done");
  endtask
  task automatic tRemote;
    tick(30);
    chk(relayDrive, 4'h0);
    @(posedge sys_clk) finalVoltage <= 1'b1;
    tick(4 * STEP + 10);
    chk(relayDrive, 4'hF);
    chk(available, 1'b1);
    chk(lampLocal, 1'b0);
    chk(lampSystemPower, 1'b1);
    chk(lampLocalPower, 1'b1);
    @(posedge sys_clk);
    localSwitch   <= 1'b1;
    powerOnSwitch <= 1'b0;
    tick(8);
    chk(relayDrive, 4'h0);
    chk(lampLocal, 1'b1);
    chk(lampLocalPower, 1'b0);
    $display("test remote done");
  endtask
  task automatic tModes;
    op(32'h0000_0004, 2, PAT, 12'h000);
    rdchk(REG_ADDR, 32'h0000_0001);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd[11:10], 2'd0);
    // slow memory here, so the sequencer must really wait for each ack
    @(posedge sys_clk) latency <= 4'h5;
    op(32'h0000_0006, 4, {1'b1, {4{12'h001}}}, 12'h001);
    rdchk(REG_ADDR, 32'h0000_0002);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd[11:10], 2'd1);
    @(posedge sys_clk) latency <= 4'h0;
    op(32'h0000_0003, 2, ALT_WORD, 12'h002);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd[11:10], 2'd2);
    $display("test modes done");
  endtask
  task automatic tError;
    apb(1'b1, REG_IRQ_EN, 32'h0000_0001);
    @(posedge sys_clk) corrupt <= 49'h0_0000_0000_0001;
    op(32'h0000_0011, 2, ~ALT_WORD, 12'h003);
    @(posedge sys_clk) corrupt <= '0;
    tick(3);
    chk(irq, 1'b1);
    chk(lampError, 1'b1);
    rdchk(REG_ERR_ADDR, 32'h0000_0003);
    rdchk(REG_ADDR, 32'h0000_0003);
    apb(1'b1, REG_IRQ_EN, 32'h0000_0000);
    tick(2);
    chk(irq, 1'b0);
    apb(1'b1, REG_IRQ_CLR, 32'h0000_000F);
    apb(1'b0, REG_IRQ_STAT, 32'h0000_0000);
    chk(rd[1:0], 2'b00);
    apb(1'b1, REG_CTRL, 32'h0000_0800);
    tick(3);
    chk(lampError, 1'b0);
    $display("test error done");
  endtask
  task automatic tClock;
    @(posedge sys_clk) stopClockOff <= 1'b1;
    tick(6);
    chk(moduleClockRun, 1'b0);
    apb(1'b1, REG_CTRL, 32'h0000_0100);
    tick(20);
    chk(memReq, 1'b0);
    // a started read would have moved the step count on
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd[9:8], 2'd0);
    chk(rd[0], 1'b0);
    @(posedge sys_clk) stopClockOff <= 1'b0;
    tick(6);
    chk(moduleClockRun, 1'b1);
    $display("test clock done");
  endtask
  task automatic tStop;
    // continuous run with stop on error: the bad first read must end the run
    @(posedge sys_clk) corrupt <= 49'h0_0000_0000_0002;
    apb(1'b1, REG_CTRL, 32'h0000_0128);
    waitReq(1'b1);
    chk(memWrite, 1'b0);
    waitReq(1'b0);
    tick(3);
    chk(memReq, 1'b0);
    @(posedge sys_clk) corrupt <= '0;
    apb(1'b0, REG_IRQ_STAT, 32'h0000_0000);
    chk(rd[3:0], 4'h5);
    apb(1'b1, REG_CTRL, 32'h0000_0200);
    rdchk(REG_ADDR, 32'h0000_0004);
    $display("test stop done");
  endtask
  task automatic tPower;
    int n;
    @(posedge sys_clk) powerOnSwitch <= 1'b1;
    n = 0;
    while (relayDrive === 4'h0 && n < 60) begin
      tick(1);
      n++;
    end
    tick(4);
    chk(relayDrive, 4'h1);
    tick(STEP);
    chk(relayDrive, 4'h3);
    tick(3 * STEP);
    chk(relayDrive, 4'hF);
    @(posedge sys_clk) powerResetBtn <= 1'b1;
    tick(6);
    @(posedge sys_clk) supplyFail <= 1'b1;
    tick(10);
    chk(supplyShutdownOeN, 1'b1);
    @(posedge sys_clk) powerResetBtn <= 1'b0;
    tick(10);
    chk(supplyShutdownOeN, 1'b0);
    chk(supplyShutdownOut, 1'b0);
    chk(relayDrive, 4'h0);
    $display("test power done");
  endtask

  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    printVerdict();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {localSwitch, stopClockOff, powerResetBtn, supplyFail, finalVoltage} = '0;
    // master clear is a remote-only path; the bench leaves it idle
    ccMasterClear = 1'b0;
    powerOnSwitch = 1'b1;
    latency = 4'h0;
    corrupt = '0;
    badCount = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    tick(6);
    tRegs();
    tRemote();
    tModes();
    tError();
    tClock();
    tStop();
    tPower();
    printVerdict();
  end
endmodule // core_memory_maintenance_test_sequencer_bench
